// file: i2c_slave_pkg.sv
// Shared constants, register map and state encoding of the I2C slave engine
package i2c_slave_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_CTRL3 = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_SADDR = 8'h10;
  localparam logic [7:0] OFF_BUF = 8'h14;
  localparam logic [7:0] OFF_EVENT = 8'h18;

  // control_reg_one fields
  localparam int CTRL1_CKP = 4;
  localparam int CTRL1_EN = 5;
  localparam int CTRL1_OV = 6;
  // control_reg_two fields
  localparam int CTRL2_SEN = 0;
  localparam int CTRL2_ACK_VALUE_SELECT = 5;
  localparam int CTRL2_RECEIVED_ACK_FLAG = 6;
  // control_reg_three fields
  localparam int CTRL3_DATA_HOLD_ENABLE = 0;
  localparam int CTRL3_ADDRESS_HOLD_ENABLE = 1;
  localparam int CTRL3_BUFFER_OVERWRITE_ENABLE = 4;
  localparam int CTRL3_START_IRQ_ENABLE = 5;
  localparam int CTRL3_PCIE = 6;
  localparam int CTRL3_ACK_WINDOW_FLAG = 7;
  // status_reg fields
  localparam int STAT_BF = 0;
  localparam int STAT_UA = 1;
  localparam int STAT_RW = 2;
  localparam int STAT_S = 3;
  localparam int STAT_P = 4;
  localparam int STAT_DA = 5;

  // Reset values
  localparam logic [3:0] MODE_RST = 4'h6;
  localparam logic [7:0] SADDR_RST = 8'h00;

  // mode_select_field encodings
  localparam logic [3:0] MODE_7 = 4'h6;
  localparam logic [3:0] MODE_10 = 4'h7;
  localparam logic [3:0] MODE_7_SP = 4'hE;
  localparam logic [3:0] MODE_10_SP = 4'hF;

  localparam logic [4:0] TEN_HI_PAT = 5'h1E;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_LO = 3'h3,
    ST_RX = 3'h2,
    ST_TX = 3'h6
  } state_e;

endpackage

// file: i2c_slave_engine.sv
// I2C slave engine with AXI4-Lite register access
`timescale 1ns/1ps
module i2c_slave_engine #(
  parameter int AXI_ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // AXI4-Lite write
  input wire logic [AXI_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic [AXI_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // I2C pins, open drain
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Event
  output logic o_serial_event
);

  // Configuration
  logic [3:0] mode_select_field;
  logic enable;
  logic stretch_enable;
  logic ack_value_select;
  logic data_hold_enable;
  logic address_hold_enable;
  logic buffer_overwrite_enable;
  logic start_irq_enable;
  logic stop_irq_enable;
  logic [7:0] slave_address_reg;
  // Engine state
  i2c_slave_pkg::state_e state;
  i2c_slave_pkg::state_e after_ack;
  logic [3:0] bit_cnt;
  logic [7:0] shift_register;
  logic [7:0] shift_buffer_reg;
  logic buffer_full;
  logic receive_overflow;
  logic address_update_needed;
  logic ua_after_ack;
  logic rw_stat;
  logic da_stat;
  logic start_stat;
  logic stop_stat;
  logic clock_release_bit;
  logic ack_window_flag;
  logic received_ack_flag;
  logic prior_match;
  logic scl_seen_low;
  logic ack_slot;
  logic ack_soft;
  logic ack_hw;
  logic serial_event_flag;
  // Synchronisers
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;
  // Bus decode
  logic [7:0] aw_addr;
  logic [7:0] ar_off;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_en, rd_en, wr_hit, rd_hit;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  // Derived
  logic mode_ok, active, ten_bit, sp_int;
  logic match7, match10hi, ovf_block, hold_now;
  logic next_sda_oe;

  // Only the second and third stages feed logic; the third is a delayed copy for edge detection
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else if (i_ce) begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s & scl_seen_low;

  assign mode_ok = (mode_select_field == i2c_slave_pkg::MODE_7) ||
                   (mode_select_field == i2c_slave_pkg::MODE_10) ||
                   (mode_select_field == i2c_slave_pkg::MODE_7_SP) ||
                   (mode_select_field == i2c_slave_pkg::MODE_10_SP);
  assign active = enable & mode_ok;
  assign ten_bit = mode_select_field[0];
  assign sp_int = mode_select_field[3];
  assign match7 = shift_register[7:1] == slave_address_reg[7:1];
  assign match10hi = (shift_register[7:3] == i2c_slave_pkg::TEN_HI_PAT) &&
                     (shift_register[2:1] == slave_address_reg[2:1]);
  assign ovf_block = receive_overflow |
                     (buffer_full & ~buffer_overwrite_enable);
  assign hold_now = (state == i2c_slave_pkg::ST_RX) ? data_hold_enable :
                    address_hold_enable;

  // AXI4-Lite handshakes; one write and one read in flight
  assign wr_en = ~o_awready & ~o_wready & ~o_bvalid;
  assign rd_en = i_arvalid & o_arready;
  assign ar_off = i_araddr[7:0];
  assign wr_byte = w_data[7:0];

  always_comb begin
    if (aw_addr == i2c_slave_pkg::OFF_CTRL1) wr_hit = 1'b1;
    else if (aw_addr == i2c_slave_pkg::OFF_CTRL2) wr_hit = 1'b1;
    else if (aw_addr == i2c_slave_pkg::OFF_CTRL3) wr_hit = 1'b1;
    else if (aw_addr == i2c_slave_pkg::OFF_STATUS) wr_hit = 1'b1;
    else if (aw_addr == i2c_slave_pkg::OFF_SADDR) wr_hit = 1'b1;
    else if (aw_addr == i2c_slave_pkg::OFF_BUF) wr_hit = 1'b1;
    else if (aw_addr == i2c_slave_pkg::OFF_EVENT) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end

  always_comb begin
    rd_hit = 1'b1;
    if (ar_off == i2c_slave_pkg::OFF_CTRL1) begin
      rd_byte = {1'b0, receive_overflow, enable, clock_release_bit,
                 mode_select_field};
    end else if (ar_off == i2c_slave_pkg::OFF_CTRL2) begin
      rd_byte = {1'b0, received_ack_flag, ack_value_select, 4'h0,
                 stretch_enable};
    end else if (ar_off == i2c_slave_pkg::OFF_CTRL3) begin
      rd_byte = {ack_window_flag, stop_irq_enable, start_irq_enable,
                 buffer_overwrite_enable, 2'h0, address_hold_enable,
                 data_hold_enable};
    end else if (ar_off == i2c_slave_pkg::OFF_STATUS) begin
      rd_byte = {2'h0, da_stat, stop_stat, start_stat, rw_stat,
                 address_update_needed, buffer_full};
    end else if (ar_off == i2c_slave_pkg::OFF_SADDR) begin
      rd_byte = slave_address_reg;
    end else if (ar_off == i2c_slave_pkg::OFF_BUF) begin
      rd_byte = shift_buffer_reg;
    end else if (ar_off == i2c_slave_pkg::OFF_EVENT) begin
      rd_byte = {7'h00, serial_event_flag};
    end else begin
      rd_byte = 8'h00;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= i2c_slave_pkg::RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        aw_addr <= i_awaddr[7:0];
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_data <= i_wdata;
        w_strb <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_en) begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_hit ? i2c_slave_pkg::RESP_OKAY :
                   i2c_slave_pkg::RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= i2c_slave_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (rd_en) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= {24'h00_0000, rd_byte};
        o_rresp <= rd_hit ? i2c_slave_pkg::RESP_OKAY :
                   i2c_slave_pkg::RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // Plain configuration, written only by software
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_select_field <= i2c_slave_pkg::MODE_RST;
      enable <= 1'b0;
      stretch_enable <= 1'b0;
      ack_value_select <= 1'b0;
      data_hold_enable <= 1'b0;
      address_hold_enable <= 1'b0;
      buffer_overwrite_enable <= 1'b0;
      start_irq_enable <= 1'b0;
      stop_irq_enable <= 1'b0;
      slave_address_reg <= i2c_slave_pkg::SADDR_RST;
    end else if (i_ce && wr_en && w_strb[0]) begin
      if (aw_addr == i2c_slave_pkg::OFF_CTRL1) begin
        mode_select_field <= wr_byte[3:0];
        enable <= wr_byte[i2c_slave_pkg::CTRL1_EN];
      end else if (aw_addr == i2c_slave_pkg::OFF_CTRL2) begin
        stretch_enable <= wr_byte[i2c_slave_pkg::CTRL2_SEN];
        ack_value_select <= wr_byte[i2c_slave_pkg::CTRL2_ACK_VALUE_SELECT];
      end else if (aw_addr == i2c_slave_pkg::OFF_CTRL3) begin
        data_hold_enable <= wr_byte[i2c_slave_pkg::CTRL3_DATA_HOLD_ENABLE];
        address_hold_enable <= wr_byte[i2c_slave_pkg::CTRL3_ADDRESS_HOLD_ENABLE];
        buffer_overwrite_enable <= wr_byte[i2c_slave_pkg::CTRL3_BUFFER_OVERWRITE_ENABLE];
        start_irq_enable <= wr_byte[i2c_slave_pkg::CTRL3_START_IRQ_ENABLE];
        stop_irq_enable <= wr_byte[i2c_slave_pkg::CTRL3_PCIE];
      end else if (aw_addr == i2c_slave_pkg::OFF_SADDR) begin
        slave_address_reg <= wr_byte;
      end
    end
  end

  // Protocol engine; software clears come first so hardware sets win
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= i2c_slave_pkg::ST_IDLE;
      after_ack <= i2c_slave_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shift_register <= 8'h00;
      shift_buffer_reg <= 8'h00;
      buffer_full <= 1'b0;
      receive_overflow <= 1'b0;
      address_update_needed <= 1'b0;
      ua_after_ack <= 1'b0;
      rw_stat <= 1'b0;
      da_stat <= 1'b0;
      start_stat <= 1'b0;
      stop_stat <= 1'b0;
      clock_release_bit <= 1'b1;
      ack_window_flag <= 1'b0;
      received_ack_flag <= 1'b0;
      prior_match <= 1'b0;
      scl_seen_low <= 1'b0;
      ack_slot <= 1'b0;
      ack_soft <= 1'b0;
      ack_hw <= 1'b0;
      serial_event_flag <= 1'b0;
    end else if (i_ce) begin
      if (wr_en && w_strb[0]) begin
        if (aw_addr == i2c_slave_pkg::OFF_CTRL1) begin
          clock_release_bit <= wr_byte[i2c_slave_pkg::CTRL1_CKP];
          if (!wr_byte[i2c_slave_pkg::CTRL1_OV]) receive_overflow <= 1'b0;
        end else if (aw_addr == i2c_slave_pkg::OFF_SADDR) begin
          address_update_needed <= 1'b0;
        end else if (aw_addr == i2c_slave_pkg::OFF_BUF) begin
          shift_buffer_reg <= wr_byte;
          shift_register <= wr_byte;
          buffer_full <= 1'b1;
        end else if (aw_addr == i2c_slave_pkg::OFF_EVENT) begin
          if (wr_byte[0]) serial_event_flag <= 1'b0;
        end
      end
      if (rd_en && ar_off == i2c_slave_pkg::OFF_BUF) buffer_full <= 1'b0;
      if (!scl_s) scl_seen_low <= 1'b1;
      if (!active) begin
        state <= i2c_slave_pkg::ST_IDLE;
        ack_slot <= 1'b0;
        ack_window_flag <= 1'b0;
      end else if (start_det) begin
        state <= i2c_slave_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        ack_slot <= 1'b0;
        ack_window_flag <= 1'b0;
        start_stat <= 1'b1;
        stop_stat <= 1'b0;
        if (sp_int || start_irq_enable) serial_event_flag <= 1'b1;
      end else if (stop_det) begin
        state <= i2c_slave_pkg::ST_IDLE;
        ack_slot <= 1'b0;
        ack_window_flag <= 1'b0;
        prior_match <= 1'b0;
        scl_seen_low <= 1'b0;
        start_stat <= 1'b0;
        stop_stat <= 1'b1;
        if (sp_int || stop_irq_enable) serial_event_flag <= 1'b1;
      end else if (scl_rise && state != i2c_slave_pkg::ST_IDLE) begin
        if (bit_cnt < 4'h9) bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt < 4'h8 && state != i2c_slave_pkg::ST_TX) begin
          shift_register <= {shift_register[6:0], sda_s};
        end
        if (bit_cnt == 4'h8 && state == i2c_slave_pkg::ST_TX) begin
          received_ack_flag <= sda_s;
        end
      end else if (scl_fall && state != i2c_slave_pkg::ST_IDLE) begin
        if (state == i2c_slave_pkg::ST_TX && bit_cnt > 4'h0 &&
            bit_cnt < 4'h8) begin
          shift_register <= {shift_register[6:0], 1'b0};
        end
        if (bit_cnt == 4'h8) begin
          // Eighth falling edge: the byte is complete
          case (state)
            i2c_slave_pkg::ST_ADDR: begin
              if ((!ten_bit && match7) || (ten_bit && match10hi &&
                  (!shift_register[0] || prior_match))) begin
                ack_slot <= 1'b1;
                ack_soft <= address_hold_enable;
                ack_hw <= ~ovf_block;
                if (buffer_full && !receive_overflow) begin
                  receive_overflow <= 1'b1;
                end
                if (!ovf_block) begin
                  shift_buffer_reg <= shift_register;
                  buffer_full <= 1'b1;
                end
                rw_stat <= shift_register[0];
                da_stat <= 1'b0;
                ua_after_ack <= ten_bit & ~shift_register[0];
                if (ten_bit && !shift_register[0]) prior_match <= 1'b0;
                if (shift_register[0]) after_ack <= i2c_slave_pkg::ST_TX;
                else if (ten_bit) after_ack <= i2c_slave_pkg::ST_ADDR_LO;
                else after_ack <= i2c_slave_pkg::ST_RX;
                if (address_hold_enable) begin
                  ack_window_flag <= 1'b1;
                  serial_event_flag <= 1'b1;
                  clock_release_bit <= 1'b0;
                end
              end else begin
                if (ten_bit) prior_match <= 1'b0;
                state <= i2c_slave_pkg::ST_IDLE;
              end
            end
            i2c_slave_pkg::ST_ADDR_LO: begin
              if (shift_register == slave_address_reg) begin
                ack_slot <= 1'b1;
                ack_soft <= address_hold_enable;
                ack_hw <= ~ovf_block;
                if (!ovf_block) begin
                  shift_buffer_reg <= shift_register;
                  buffer_full <= 1'b1;
                end
                prior_match <= 1'b1;
                ua_after_ack <= 1'b1;
                after_ack <= i2c_slave_pkg::ST_RX;
                if (address_hold_enable) begin
                  ack_window_flag <= 1'b1;
                  serial_event_flag <= 1'b1;
                  clock_release_bit <= 1'b0;
                end
              end else begin
                serial_event_flag <= 1'b1;
                address_update_needed <= 1'b1;
                state <= i2c_slave_pkg::ST_IDLE;
              end
            end
            i2c_slave_pkg::ST_RX: begin
              ack_slot <= 1'b1;
              ack_soft <= data_hold_enable;
              ack_hw <= ~ovf_block;
              if (buffer_full && !receive_overflow) receive_overflow <= 1'b1;
              if (!ovf_block) begin
                shift_buffer_reg <= shift_register;
                buffer_full <= 1'b1;
              end
              da_stat <= 1'b1;
              after_ack <= i2c_slave_pkg::ST_RX;
              if (data_hold_enable) begin
                ack_window_flag <= 1'b1;
                serial_event_flag <= 1'b1;
                clock_release_bit <= 1'b0;
              end
            end
            default: begin
              buffer_full <= 1'b0;
              da_stat <= 1'b1;
            end
          endcase
        end else if (bit_cnt == 4'h9) begin
          // Ninth falling edge: the acknowledge slot ends
          bit_cnt <= 4'h0;
          ack_slot <= 1'b0;
          ack_window_flag <= 1'b0;
          if (state == i2c_slave_pkg::ST_TX) begin
            serial_event_flag <= 1'b1;
            if (received_ack_flag) begin
              state <= i2c_slave_pkg::ST_IDLE;
            end else begin
              clock_release_bit <= 1'b0;
            end
          end else if (ack_slot) begin
            if (!hold_now || o_sda_oe) serial_event_flag <= 1'b1;
            if (!o_sda_oe) begin
              state <= i2c_slave_pkg::ST_IDLE;
            end else begin
              state <= after_ack;
              if (ua_after_ack) begin
                address_update_needed <= 1'b1;
              end else if (after_ack == i2c_slave_pkg::ST_TX) begin
                clock_release_bit <= 1'b0;
              end else if (stretch_enable) begin
                clock_release_bit <= 1'b0;
              end
            end
          end
        end
      end
    end
  end

  always_comb begin
    next_sda_oe = 1'b0;
    if (!active || start_det || stop_det) begin
      next_sda_oe = 1'b0;
    end else if (state == i2c_slave_pkg::ST_TX && bit_cnt < 4'h8) begin
      next_sda_oe = ~shift_register[7];
    end else if (ack_slot && bit_cnt >= 4'h8) begin
      next_sda_oe = ack_soft ? ~ack_value_select : ack_hw;
    end
  end

  // Pins: outputs only ever pull low
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_serial_event <= 1'b0;
    end else if (i_ce) begin
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      // Grabbing SCL while high would cut the master's pulse short
      o_scl_oe <= active & (~clock_release_bit | address_update_needed) &
                  (o_scl_oe | ~scl_s);
      o_sda_oe <= next_sda_oe;
      o_serial_event <= serial_event_flag;
    end
  end

endmodule // i2c_slave_engine

// file: i2c_slave_asserts.sv
// Port assertions for the I2C slave engine
`timescale 1ns/1ps
module i2c_slave_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Pins
  input wire logic i_scl,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_serial_event,
  // Bus responses
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_pins; o_scl_out == 1'b0 && o_sda_out == 1'b0; endproperty
  a_pins: assert property (p_pins) else $error("pin data high");
  // The pin reaches the logic two flops late, so look back past them
  property p_hold; $rose(o_scl_oe) |-> !$past(i_scl, 2); endproperty
  a_hold: assert property (p_hold) else $error("stretch on high");
  property p_free; $fell(o_scl_oe) |-> $past(o_bvalid) || $past(o_bvalid, 2);
  endproperty
  a_free: assert property (p_free) else $error("release unasked");
  property p_sda; $changed(o_sda_oe) |-> !i_scl && !$past(i_scl); endproperty
  a_sda: assert property (p_sda) else $error("sda moved on high");
  property p_evt; $fell(o_serial_event) |-> $past(o_bvalid) ||
    $past(o_bvalid, 2); endproperty
  a_evt: assert property (p_evt) else $error("event lost");
  property p_bh; o_bvalid && !i_bready |=> o_bvalid; endproperty
  a_bh: assert property (p_bh) else $error("write answer dropped");
  property p_rh; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rh: assert property (p_rh) else $error("read answer dropped");
  property p_ru; o_rvalid |-> o_rdata[31:8] == 24'h0; endproperty
  a_ru: assert property (p_ru) else $error("read upper bits set");
endmodule // i2c_slave_asserts
bind i2c_slave_engine i2c_slave_asserts u_chk (.*);

// file: i2c_master_model.sv
// Behavioural I2C bus master for the slave engine
`timescale 1ns/1ps
module i2c_master_model (
  // Device pin enables
  input wire logic i_scl_oe,
  input wire logic i_sda_oe,
  // Wire levels
  output logic o_scl,
  output logic o_sda
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // Pull-ups: a released line floats high
  assign o_scl = !(scl_low || i_scl_oe);
  assign o_sda = !(sda_low || i_sda_oe);
  // Waiting on the wire lets the device stretch any low phase
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low = !b;
    #160 scl_low = 1'b0;
    wait (o_scl);
    #60 r = o_sda;
    #60 scl_low = 1'b1;
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bit_io(d[i], q[i]);
    #160;
  endtask
  task automatic start();
    sda_low = 1'b0;
    #100 scl_low = 1'b0;
    wait (o_scl);
    #60 sda_low = 1'b1;
    #60 scl_low = 1'b1;
  endtask
  task automatic stop();
    #40 sda_low = 1'b1;
    #160 scl_low = 1'b0;
    wait (o_scl);
    #60 sda_low = 1'b0;
    #160;
  endtask
endmodule // i2c_master_model

// file: tb.sv
// Self-checking bench for the I2C slave engine
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0, i_scl, i_sda;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_scl_oe;
  logic o_sda_oe, o_serial_event;
  logic [1:0] o_bresp, o_rresp, rs;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, sa;
  logic [8:0] r9;
  logic [31:0] i_wdata = 32'h0, o_rdata, q, seed = 32'h804FE28E;
  logic [4:0] mt [5] = '{5'h16, 5'h06, 5'h07, 5'h0E, 5'h0F};
  int mismatches = 0, checked = 0, cycles = 0;
  byte unsigned bq [$];
  i2c_slave_engine uut (.*, .i_ce(1'b1), .i_wstrb(4'hF),
    .o_scl_out(), .o_sda_out());
  i2c_master_model m (.i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe),
    .o_scl(i_scl), .o_sda(i_sda));
  initial forever #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      end_sim();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input bit we, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_awaddr, i_araddr, i_wdata} <= {a, a, d};
    {i_awvalid, i_wvalid, i_arvalid} <= {we, we, !we};
    // Ready stands from the request so the answer is taken where it is seen
    {i_bready, i_rready} <= {we, !we};
    do begin
      @(posedge i_clk);
      {i_awvalid, i_wvalid, i_arvalid} <= {i_awvalid & !o_awready,
        i_wvalid & !o_wready, i_arvalid & !o_arready};
    end while (!(we ? o_bvalid : o_rvalid));
    q = we ? {30'h0, o_bresp} : o_rdata;
    rs = o_rresp;
    {i_bready, i_rready} <= 2'b00;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rchk(8'h00, 32'h16);
    rchk(8'h1C, 32'h0);
    chk(rs, 2'h2);
    acc(1'b1, 8'h1C, 32'h0);
    chk(q, 32'h2);
    foreach (mt[i]) begin
      acc(1'b1, 8'h08, {26'h0, mt[i][4], 5'h0});
      acc(1'b1, 8'h00, {28'h3, mt[i][3:0]});
      acc(1'b1, 8'h18, 32'h1);
      m.start();
      m.stop();
      rchk(8'h18, {31'h0, mt[i][4] | mt[i][3]});
    end
    sa = {seed[6:0] | 7'h08, 1'b0};
    acc(1'b1, 8'h00, 32'h36);
    acc(1'b1, 8'h10, {24'h0, sa});
    m.start();
    m.xfer({sa, 1'b1}, r9);
    chk(r9[0], 1'b0);
    bq.push_back(sa);
    rchk(8'h14, bq.pop_front());
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      m.xfer({seed[7:0], 1'b1}, r9);
      chk(r9[0], i);
      if (i == 0) bq.push_back(seed[7:0]);
    end
    rchk(8'h00, 32'h76);
    rchk(8'h14, bq.pop_front());
    acc(1'b1, 8'h00, 32'h36);
    m.start();
    m.xfer({sa | 8'h01, 1'b1}, r9);
    chk(r9[0], 1'b0);
    rchk(8'h00, 32'h26);
    acc(1'b0, 8'h0C, 32'h0);
    chk(q[2:0], 3'h5);
    rchk(8'h14, {24'h0, sa | 8'h01});
    seed = lfsr(seed);
    acc(1'b1, 8'h14, {24'h0, seed[7:0]});
    acc(1'b1, 8'h00, 32'h36);
    m.xfer(9'h1FF, r9);
    chk(r9[8:1], seed[7:0]);
    rchk(8'h04, 32'h40);
    m.start();
    m.xfer({sa ^ 8'h02, 1'b1}, r9);
    chk(r9[0], 1'b1);
    acc(1'b1, 8'h08, 32'h2);
    acc(1'b1, 8'h18, 32'h1);
    m.start();
    fork
      m.xfer({sa, 1'b1}, r9);
      begin
        while (!o_serial_event) @(posedge i_clk);
        rchk(8'h08, 32'h82);
        rchk(8'h00, 32'h26);
        acc(1'b1, 8'h04, 32'h20);
        acc(1'b1, 8'h00, 32'h36);
      end
    join
    chk(r9[0], 1'b1);
    m.stop();
    end_sim();
  end
endmodule // tb
